// File: bench/ddrwp_link_properties.sv
// Purpose: link timing and framing checks between the two ends
// Assumes: clk_sys samples every link line; half period of 4 sys cycles
// Notes:   watches the link lines and both ends' output enables only, never the bench inputs
`timescale 1ns/100ps
module ddrwp_link_properties (
    input logic       clk_sys,
    input logic       reset_n,
    input logic       bus_clock,
    input logic       bus_clock_complement,
    input logic       select_n,
    input logic       host_dq_oe,
    input logic       dev_dq_oe,
    input logic       host_rws_oe,
    input logic       dev_rws_oe,
    input logic [7:0] dq,
    input logic       read_write_strobe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // an odd edge count would leave the clock high once the frame closes
    property p_idle; select_n |-> !bus_clock; endproperty
    property p_comp; bus_clock_complement == !bus_clock; endproperty
    // the clock never pauses high, so no half word can stall
    property p_half; $rose(bus_clock) |-> bus_clock[*4] ##1 !bus_clock; endproperty
    property p_one_drv; !(host_dq_oe && dev_dq_oe); endproperty
    // write data settles a cycle before the edge and stays after it
    property p_center; host_dq_oe && $changed(bus_clock) |=> $stable(dq); endproperty
    // device data moves only together with its strobe
    property p_aligned;
        dev_dq_oe && $past(dev_dq_oe) && !host_dq_oe && !$past(host_dq_oe) && $changed(dq)
            |-> $changed(read_write_strobe);
    endproperty
    property p_rise; dev_rws_oe && $rose(bus_clock) |-> ##[1:6] $rose(read_write_strobe); endproperty
    property p_fall; dev_rws_oe && $fell(bus_clock) |-> ##[1:6] $fell(read_write_strobe); endproperty
    property p_no_mask; !host_rws_oe; endproperty
    a_idle: assert property (p_idle) else $error("clock high outside frame");
    a_comp: assert property (p_comp) else $error("clock complement wrong");
    a_half: assert property (p_half) else $error("clock high phase not four cycles");
    a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
    a_center: assert property (p_center) else $error("write data moved at clock edge");
    a_aligned: assert property (p_aligned) else $error("read data moved without strobe");
    a_rise: assert property (p_rise) else $error("no strobe rise for clock rise");
    a_fall: assert property (p_fall) else $error("no strobe fall for clock fall");
    a_no_mask: assert property (p_no_mask) else $error("host drove strobe");
    c_read: cover property ($rose(read_write_strobe));
    c_frame: cover property ($fell(select_n));
    c_write: cover property (host_dq_oe && $rose(bus_clock));
endmodule : ddrwp_link_properties

// File: bench/testbench.sv
// Purpose: host and device joined by the link, checked end to end
// Assumes: inputs change on falling clk_sys; status word held constant
// Notes:   memory words are read back in both byte orders
`timescale 1ns/100ps
module testbench;
    import ddrwp_pkg::*;
    logic              clk_sys = 1'b0;                // system clock
    logic              reset_n = 1'b0;                // async reset, active low
    logic              cmd_valid = 1'b0;              // command offered
    logic              cmd_read = 1'b0;               // 1 = read
    logic              cmd_reg = 1'b0;                // 1 = register space
    logic              cmd_le = 1'b0;                 // 1 = little-endian placement
    logic [ADDR_W-1:0] cmd_addr = '0;                 // start word address
    logic [7:0]        cmd_words = 8'h00;             // word count
    logic              wr_valid = 1'b0;               // write word offered
    logic [15:0]       wr_data = 16'h0000;            // write word
    wire               cmd_ready, wr_ready, rd_valid, busy;
    wire  [15:0]       rd_data, cfg_word;
    int                n_fail = 0;                    // mismatches
    int                comparisons = 0;               // checks made
    logic [7:0]        wq[$];                         // host bytes at bus clock edges
    logic [15:0]       mem[$] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081};
    always #50 clk_sys = ~clk_sys;
    ddrwp_if bus ();
    ddrwp_host ddrwp_host_i (.clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_reg_space(cmd_reg), .cmd_little_endian(cmd_le), .cmd_addr(cmd_addr),
        .cmd_words(cmd_words), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .bus(bus));
    ddrwp_device ddrwp_device_i (.clk_sys(clk_sys), .reset_n(reset_n), .status_word(16'hbeef),
        .cfg_word(cfg_word), .selected(), .bus(bus));
    ddrwp_link_properties ddrwp_link_properties_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus_clock(bus.bus_clock), .bus_clock_complement(bus.bus_clock_complement), .select_n(bus.select_n),
        .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe), .host_rws_oe(bus.host_rws_oe),
        .dev_rws_oe(bus.dev_rws_oe), .dq(bus.dq), .read_write_strobe(bus.read_write_strobe));
    // data already settled when the host moves its clock
    always @(bus.bus_clock) if (bus.host_dq_oe === 1'b1) wq.push_back(bus.dq);
    function automatic logic [15:0] sw(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction : sw
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // offer words back to back; only used on an empty buffer
    task automatic fill(input logic [15:0] w[$]);
        foreach (w[i]) begin
            @(negedge clk_sys);
            wr_valid = 1'b1;
            wr_data = w[i];
        end
        @(negedge clk_sys);
        wr_valid = 1'b0;
    endtask : fill
    // one frame; read words are compared in arrival order
    task automatic xfer(input logic rd, rg, le, input logic [13:0] a, input logic [7:0] n,
                        input logic [15:0] exp[$]);
        int k = 0;
        wq.delete();
        @(negedge clk_sys);
        {cmd_read, cmd_reg, cmd_le, cmd_addr, cmd_words} = {rd, rg, le, a, n};
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        repeat (3000) begin
            @(negedge clk_sys);
            if (rd_valid === 1'b1) begin
                chk("read word", exp[k], rd_data);
                k++;
            end
            if (busy === 1'b0) break;
        end
        chk("frame end and word count", {8'h00, rd ? n : 8'h00}, {7'h00, busy, 8'(k)});
    endtask : xfer
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        // register write asks for little-endian but must travel high byte first
        fill('{16'h1234});
        xfer(1'b0, 1'b1, 1'b1, 14'h0000, 8'h01, '{});
        chk("reg first byte", 16'h0012, {8'h00, wq[2]});
        chk("reg second byte", 16'h0034, {8'h00, wq[3]});
        chk("cfg word", 16'h1234, cfg_word);
        // three registers in one frame; index 2 is unmapped and reads zero
        xfer(1'b1, 1'b1, 1'b0, 14'h0000, 8'h03, '{16'h1234, 16'hbeef, 16'h0000});
        // fill the buffer until it refuses, then one frame drains it
        fill(mem);
        chk("buffer full", 16'h0000, {15'h0000, wr_ready});
        xfer(1'b0, 1'b0, 1'b1, 14'h0005, 8'h04, '{});
        chk("low byte first", {8'h00, mem[0][7:0]}, {8'h00, wq[2]});
        chk("buffer empty", 16'h0001, {15'h0000, wr_ready});
        xfer(1'b1, 1'b0, 1'b1, 14'h0005, 8'h04, mem);
        // the other placement sees the stored bytes swapped
        xfer(1'b1, 1'b0, 1'b0, 14'h0005, 8'h04, '{sw(mem[0]), sw(mem[1]), sw(mem[2]), sw(mem[3])});
        summarize();
    end
    // frames take a few dozen cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
endmodule : testbench

// File: design/ddrwp_device.sv
// Purpose: device end: captures command and write bytes, stores words, drives read bytes
// Assumes: host makes the bus clock; all link inputs sampled by clk_sys through two flops
// Notes:   memory keeps bytes as received, so host byte order is returned untouched
`timescale 1ns/100ps
module ddrwp_device #(
    parameter int MEM_AW = 8  // memory words = 2**MEM_AW
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [15:0] status_word,
    output logic [15:0]      cfg_word,
    output logic             selected,
    ddrwp_if.device          bus
);
    import ddrwp_pkg::*;

    typedef enum logic [2:0] {D_IDLE, D_CMD_HI, D_CMD_LO, D_WRITE, D_READ} ddrwp_dev_t;

    typedef struct packed {
        ddrwp_dev_t        st;       // transfer state
        logic [1:0]        clk_s;    // bus clock synchroniser
        logic              clk_p;    // previous synchronised bus clock
        logic [1:0]        cs_s;     // select synchroniser
        logic [7:0]        dq_s0;    // data synchroniser, first stage
        logic [7:0]        dq_s1;    // data synchroniser, second stage
        logic [7:0]        cmd_hi;   // first command byte
        logic              reg_sp;   // register space access
        logic [ADDR_W-1:0] addr;     // current word address
        logic [7:0]        a_hold;   // first byte of an incoming word
        logic [15:0]       rd_word;  // word prefetched for reading
        logic [7:0]        dq;       // data out
        logic              dq_oe;    // data out enable
        logic              rws;      // read strobe level
        logic              rws_oe;   // read strobe enable
        logic [15:0]       cfg;      // configuration register
    } ddrwp_dev_st_t;

    ddrwp_dev_st_t q, d;

    logic [15:0] mem [0:(1<<MEM_AW)-1];  // word store, no reset
    logic        mem_we;                 // store a word this cycle
    logic        edge_seen;              // bus clock changed
    logic        rise;                   // bus clock rose
    logic [15:0] cmd_word;               // full command word at its second byte

    // word fetch for either space
    function automatic logic [15:0] fetch(input logic sp, input logic [ADDR_W-1:0] a);
        logic [15:0] r;
        if (sp) begin
            r = (a == ADDR_W'(REG_CFG_IDX)) ? q.cfg :
                (a == ADDR_W'(REG_STATUS_IDX)) ? status_word : WORD_RST;
        end else begin
            r = mem[a[MEM_AW-1:0]];
        end
        return r;
    endfunction : fetch

    assign edge_seen = q.clk_s[1] ^ q.clk_p;
    assign rise      = edge_seen & q.clk_s[1];
    assign cmd_word  = {q.cmd_hi, q.dq_s1};

    // link sampling and transfer sequencing
    always_comb begin
        d        = q;
        mem_we   = 1'b0;
        // two-flop sampling; first stages feed only the second
        d.clk_s  = {q.clk_s[0], bus.bus_clock};
        d.clk_p  = q.clk_s[1];
        d.cs_s   = {q.cs_s[0], bus.select_n};
        d.dq_s0  = bus.dq;
        d.dq_s1  = q.dq_s0;
        if (q.cs_s[1]) begin
            // deselect ends any transfer and frees the lines
            d.st     = D_IDLE;
            d.dq_oe  = 1'b0;
            d.rws_oe = 1'b0;
            d.rws    = 1'b0;
        end else begin
            case (q.st)
                D_IDLE: begin
                    d.st = D_CMD_HI;
                end
                D_CMD_HI: begin
                    if (rise) begin
                        d.cmd_hi = q.dq_s1;
                        d.st     = D_CMD_LO;
                    end
                end
                D_CMD_LO: begin
                    if (edge_seen) begin
                        d.reg_sp = cmd_word[CMD_SPACE_BIT];
                        d.addr   = cmd_word[ADDR_W-1:0];
                        if (cmd_word[CMD_READ_BIT]) begin
                            d.rd_word = fetch(cmd_word[CMD_SPACE_BIT], cmd_word[ADDR_W-1:0]);
                            d.rws_oe  = 1'b1;  // strobe starts low
                            d.rws     = 1'b0;
                            d.st      = D_READ;
                        end else begin
                            d.st = D_WRITE;
                        end
                    end
                end
                D_WRITE: begin
                    if (rise) begin
                        d.a_hold = q.dq_s1;
                    end else if (edge_seen) begin
                        // a word is only stored once both bytes arrived
                        if (q.reg_sp) begin
                            if (q.addr == ADDR_W'(REG_CFG_IDX)) begin
                                d.cfg = {q.a_hold, q.dq_s1};
                            end
                        end else begin
                            mem_we = 1'b1;
                        end
                        d.addr = q.addr + ADDR_W'(1);
                    end
                end
                D_READ: begin
                    // byte and strobe change together: edge-aligned output
                    if (rise) begin
                        d.dq    = q.rd_word[15:8];
                        d.dq_oe = 1'b1;
                        d.rws   = 1'b1;
                    end else if (edge_seen) begin
                        d.dq      = q.rd_word[7:0];
                        d.rws     = 1'b0;
                        d.addr    = q.addr + ADDR_W'(1);
                        d.rd_word = fetch(q.reg_sp, q.addr + ADDR_W'(1));
                    end
                end
                default: begin
                    d.st = D_IDLE;
                end
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q      <= '0;
            q.st   <= D_IDLE;
            q.cs_s <= 2'b11;
            q.cfg  <= WORD_RST;
        end else begin
            q <= d;
        end
    end

    // bytes kept in arrival order: first byte high, second low
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[q.addr[MEM_AW-1:0]] <= {q.a_hold, q.dq_s1};
        end
    end

    assign cfg_word       = q.cfg;
    assign selected       = ~q.cs_s[1];
    assign bus.dev_dq_o   = q.dq;
    assign bus.dev_dq_oe  = q.dq_oe;
    assign bus.dev_rws_o  = q.rws;
    assign bus.dev_rws_oe = q.rws_oe;
endmodule : ddrwp_device

// File: design/ddrwp_host.sv
// Purpose: host end: frames transfers, makes the bus clock, places and assembles words
// Assumes: clk_sys at 10 MHz; device answers reads with no extra latency
// Notes:   write data passes a small fifo; the bus clock pauses while it runs dry
//
// How it works
// - device drives read bytes with each strobe change
// - only whole 16-bit words are moved
// - one word per clock, address advances each
// - byte bit 7 on line 7, bit 0 on line 0
// - register space words always travel big-endian
// - device stores first byte as A, second B
// - memory returns bytes exactly as written
// - little-endian host gets little-endian order back
// - register writes: high byte rising, low falling
// - host write data changes one sys cycle before each clock edge
`timescale 1ns/100ps

// write data buffer; depth must be a power of two
module ddrwp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage words
        logic [AW-1:0]               wp;   // write pointer
        logic [AW-1:0]               rp;   // read pointer
        logic [AW:0]                 cnt;  // words held
    } ddrwp_fifo_st_t;

    ddrwp_fifo_st_t q, d;
    logic push, pop;

    // handshakes are combinational from the fill count
    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and count update
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : ddrwp_fifo

module ddrwp_host #(
    parameter int LEN_W      = 8,  // width of the word count of one transfer
    parameter int FIFO_DEPTH = 4   // write buffer depth
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire logic                 cmd_read,
    input  wire logic                 cmd_reg_space,
    input  wire logic                 cmd_little_endian,
    input  wire logic [ddrwp_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [LEN_W-1:0]     cmd_words,
    input  wire logic                 wr_valid,
    output logic                      wr_ready,
    input  wire logic [15:0]          wr_data,
    output logic                      rd_valid,
    output logic [15:0]               rd_data,
    output logic                      busy,
    ddrwp_if.host                     bus
);
    import ddrwp_pkg::*;

    localparam int PH_W = $clog2(LINK_HALF_CYC) + 1;  // phase counter width
    localparam int EW   = LEN_W + 2;                   // edge counter width

    typedef enum logic [1:0] {H_IDLE, H_RUN, H_TAIL} ddrwp_hst_t;

    typedef struct packed {
        ddrwp_hst_t       st;        // transfer state
        logic [PH_W-1:0]  ph;        // sys cycles into the current half period
        logic [EW-1:0]    edge_n;    // bus clock edges made so far
        logic [EW-1:0]    edge_last; // index of the last edge of the transfer
        logic [LEN_W-1:0] words;     // words in this transfer
        logic [LEN_W-1:0] rx_cnt;    // read words assembled
        logic             rd;        // transfer is a read
        logic             le;        // little-endian placement in force
        logic [15:0]      cmd;       // command word being sent
        logic             clk_out;   // bus clock level
        logic             cs_n;      // select line level
        logic [7:0]       dq;        // data out
        logic             dq_oe;     // data out enable
        logic [7:0]       b_hold;    // second byte of the word being written
        logic [1:0]       rws_s;     // strobe synchroniser
        logic             rws_p;     // previous synchronised strobe
        logic [7:0]       dq_s0;     // data synchroniser, first stage
        logic [7:0]       dq_s1;     // data synchroniser, second stage
        logic [7:0]       a_cap;     // first byte of an incoming word
        logic             rd_valid;  // assembled word ready, one cycle
        logic [15:0]      rd_data;   // assembled word
    } ddrwp_hst_st_t;

    ddrwp_hst_st_t q, d;

    logic        f_valid;  // fifo holds a write word
    logic        f_pop;    // take a write word from the fifo
    logic [15:0] f_data;   // word at the fifo head
    logic [15:0] place;    // placed {first, second} bytes of the head word
    logic        stall;    // write word missing at a data change point

    // write data path; wr_ready is true back-pressure from the buffer
    ddrwp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wbuf (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    assign place = ddrwp_place(f_data, q.le);

    // sequencing, clock divider and read assembly
    always_comb begin
        d          = q;
        f_pop      = 1'b0;
        stall      = 1'b0;
        d.rd_valid = 1'b0;
        // strobe and data pass two flops before use; first stage feeds only the second
        d.rws_s = {q.rws_s[0], bus.read_write_strobe};
        d.rws_p = q.rws_s[1];
        d.dq_s0 = bus.dq;
        d.dq_s1 = q.dq_s0;
        case (q.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    // zero words is taken as one so a transfer never ends mid-word
                    d.words     = (cmd_words == '0) ? LEN_W'(1) : cmd_words;
                    d.edge_last = EW'({1'b0, d.words, 1'b0}) + EW'(CMD_EDGES - 1);
                    d.st        = H_RUN;
                    d.ph        = '0;
                    d.edge_n    = '0;
                    d.rx_cnt    = '0;
                    d.rd        = cmd_read;
                    d.le        = cmd_little_endian & ~cmd_reg_space;
                    d.cmd       = {cmd_read, cmd_reg_space, cmd_addr};
                    d.cs_n      = 1'b0;
                end
            end
            H_RUN: begin
                // data changes one sys cycle before each clock edge
                if (q.ph == PH_W'(LINK_CENTER_CYC)) begin
                    if (q.edge_n == EW'(0)) begin
                        d.dq    = q.cmd[15:8];
                        d.dq_oe = 1'b1;  // late turn-on: a device still ending a read lets go first
                    end else if (q.edge_n == EW'(1)) begin
                        d.dq = q.cmd[7:0];
                    end else if (!q.rd) begin
                        if (!q.edge_n[0]) begin
                            // rising edge carries the first byte, falling the second
                            if (f_valid) begin
                                f_pop    = 1'b1;
                                d.dq     = place[15:8];
                                d.b_hold = place[7:0];
                            end else begin
                                // pause the clock rather than send half a word
                                stall = 1'b1;
                            end
                        end else begin
                            d.dq = q.b_hold;
                        end
                    end else begin
                        d.dq_oe = 1'b0;  // hand the lines to the device
                    end
                end
                if (!stall) begin
                    if (q.ph == PH_W'(LINK_HALF_CYC - 1)) begin
                        d.ph      = '0;
                        d.clk_out = ~q.clk_out;
                        d.edge_n  = q.edge_n + EW'(1);
                        if (q.edge_n == q.edge_last) begin
                            d.st = H_TAIL;
                        end
                    end else begin
                        d.ph = q.ph + PH_W'(1);
                    end
                end
            end
            H_TAIL: begin
                // keep the last write byte past its edge, then release
                if (q.ph == PH_W'(LINK_CENTER_CYC)) begin
                    d.dq_oe = 1'b0;
                end
                if (q.ph != PH_W'(LINK_HALF_CYC - 1)) begin
                    d.ph = q.ph + PH_W'(1);
                end else if (!q.rd || (q.rx_cnt == q.words)) begin
                    d.cs_n = 1'b1;
                    d.st   = H_IDLE;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
        // read bytes are taken on each strobe change, rising then falling
        if (q.rd && !q.cs_n && (q.rws_s[1] != q.rws_p)) begin
            if (q.rws_s[1]) begin
                d.a_cap = q.dq_s1;
            end else begin
                d.rd_valid = 1'b1;
                d.rd_data  = ddrwp_place({q.a_cap, q.dq_s1}, q.le);
                d.rx_cnt   = q.rx_cnt + LEN_W'(1);
            end
        end
    end

    // single state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q      <= '0;
            q.st   <= H_IDLE;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign cmd_ready                = (q.st == H_IDLE);
    assign busy                     = ~q.cs_n;
    assign rd_valid                 = q.rd_valid;
    assign rd_data                  = q.rd_data;
    assign bus.bus_clock            = q.clk_out;
    assign bus.bus_clock_complement = ~q.clk_out;
    assign bus.select_n             = q.cs_n;
    assign bus.host_dq_o            = q.dq;
    assign bus.host_dq_oe           = q.dq_oe;
    assign bus.host_rws_o           = 1'b0;  // full words only, no write mask
    assign bus.host_rws_oe          = 1'b0;
endmodule : ddrwp_host

// File: design/ddrwp_if.sv
// Purpose: link between host end and device end
// Assumes: host makes the bus clock; shared lines resolve from the output enables
// Notes:   an undriven shared line reads low
`timescale 1ns/100ps
interface ddrwp_if;
    logic       bus_clock;             // host-made link clock
    logic       bus_clock_complement;  // inverse of bus_clock
    logic       select_n;              // transfer framing, active low
    logic [7:0] host_dq_o;             // host data out
    logic       host_dq_oe;            // host drives data lines
    logic [7:0] dev_dq_o;              // device data out
    logic       dev_dq_oe;             // device drives data lines
    logic       host_rws_o;            // host strobe out (unused, full words only)
    logic       host_rws_oe;           // host drives strobe
    logic       dev_rws_o;             // device read strobe
    logic       dev_rws_oe;            // device drives strobe
    logic [7:0] dq;                    // resolved data lines
    logic       read_write_strobe;     // resolved strobe line

    // resolve shared lines from the enables
    assign dq = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : 8'h00);
    assign read_write_strobe = host_rws_oe ? host_rws_o : (dev_rws_oe ? dev_rws_o : 1'b0);

    modport host (
        output bus_clock, bus_clock_complement, select_n,
        output host_dq_o, host_dq_oe, host_rws_o, host_rws_oe,
        input  dq, read_write_strobe
    );

    modport device (
        input  bus_clock, bus_clock_complement, select_n,
        output dev_dq_o, dev_dq_oe, dev_rws_o, dev_rws_oe,
        input  dq, read_write_strobe
    );
endinterface : ddrwp_if

// File: design/ddrwp_pkg.sv
// Purpose: shared constants, types and byte placement for the ddr word placement link
// Assumes: clk_sys at 10 MHz; both ends use the same constants
// Notes:   the link clock half period is derived from the system clock period
package ddrwp_pkg;

    // system clock and link clock timing
    localparam int SYS_PERIOD_NS   = 100;                          // clk_sys period
    localparam int LINK_HALF_NS    = 400;                          // half period of the bus clock
    localparam int LINK_HALF_CYC   = LINK_HALF_NS / SYS_PERIOD_NS; // sys cycles per bus clock half
    localparam int LINK_CENTER_CYC = LINK_HALF_CYC / 2;            // data change point inside a half

    // command word layout (sent as the first word of every transfer)
    localparam int CMD_READ_BIT  = 15;  // 1 = read, 0 = write
    localparam int CMD_SPACE_BIT = 14;  // 1 = register space, 0 = memory space
    localparam int ADDR_W        = 14;  // word address field, bits 13..0
    localparam int CMD_EDGES     = 2;   // bus clock edges taken by the command word

    // register space map (word index)
    localparam int REG_CFG_IDX    = 0;  // read/write configuration word
    localparam int REG_STATUS_IDX = 1;  // read-only status word

    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0]  BYTE_RST = 8'h00;

    typedef logic [15:0] ddrwp_word_t;

    // word to {first byte, second byte} and back; the mapping is its own inverse
    // big-endian: first byte is bits 15:8; little-endian: first byte is bits 7:0
    function automatic ddrwp_word_t ddrwp_place(input ddrwp_word_t w, input logic le);
        ddrwp_word_t r;
        r = le ? {w[7:0], w[15:8]} : w;
        return r;
    endfunction : ddrwp_place

endpackage : ddrwp_pkg
